// [rtl/acsr_core.v]
// Conversion sequencer and serial readout of one 8-bit result
`timescale 1ns/1ps
`default_nettype none
`include "acsr_map.vh"
module acsr_core #(
    parameter RES_BITS = `ACSR_RES_BITS,
    parameter CONV_NS = `ACSR_CONV_TIME_NS
) (
    input wire clk,                       // 40 MHz clock
    input wire srst,                      // Synchronous reset, active high
    input wire ce,                        // Clock enable, freezes state when low
    input wire convert_start_n,           // Convert-start pin, active low edge
    input wire sclk,                      // Serial clock pin from master
    input wire [RES_BITS-1:0] sample_in,  // Digitised analog input channel
    input wire [RES_BITS-1:0] half_in,    // Digitised half-supply reference
    output reg dout,                      // Serial data output
    output reg dout_oe_n,                 // Output enable, low while driving
    output reg busy,                      // Conversion in progress
    output reg sel_half,                  // Input multiplexer on half supply
    output reg [RES_BITS-1:0] result      // Last conversion result
);

    // ********************************************
    // Timing derived from clock rate
    // ********************************************
    // Start latency through the synchroniser counts against the budget
    localparam integer TOTAL_CYC = CONV_NS / `ACSR_CLK_PERIOD_NS;
    localparam integer DONE_CYC = TOTAL_CYC - `ACSR_SYNC_CYCLES - 1;
    localparam [`ACSR_CNT_W-1:0] CONV_CYC = DONE_CYC[`ACSR_CNT_W-1:0];
    localparam [`ACSR_CNT_W-1:0] ACQ_CYC = `ACSR_ACQ_CYCLES;
    localparam [`ACSR_BIT_CNT_W-1:0] BITS_INIT = RES_BITS[`ACSR_BIT_CNT_W-1:0];
    localparam [`ACSR_BIT_CNT_W-1:0] BIT_ONE = {{(`ACSR_BIT_CNT_W-1){1'b0}}, 1'b1};

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_TRACK = 2'h1;
    localparam [1:0] ST_CONV = 2'h2;
    localparam [1:0] ST_SHIFT = 2'h3;

    // ********************************************
    // Pin synchronisers and edge detection
    // ********************************************
    localparam NPINS = 2;
    localparam PIN_CS = 0;
    localparam PIN_SC = 1;
    // Power up with both pins taken high so a low start pin gives a falling edge and starts a conversion
    localparam [NPINS-1:0] PIN_RST = `ACSR_PIN_RST;

    wire [NPINS-1:0] pin_raw;
    wire [NPINS-1:0] pin_s;
    wire [NPINS-1:0] pin_d;

    assign pin_raw[PIN_CS] = convert_start_n;
    assign pin_raw[PIN_SC] = sclk;

    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_sync
            reg m;
            reg s;
            reg d;
            always @(posedge clk) begin
                if (srst) begin
                    m <= PIN_RST[gi];
                    s <= PIN_RST[gi];
                    d <= PIN_RST[gi];
                end else if (ce) begin
                    m <= pin_raw[gi];
                    s <= m;
                    d <= s;
                end
            end
            assign pin_s[gi] = s;
            assign pin_d[gi] = d;
        end
    endgenerate

    // Edge decode: falling edge used on both pins, rising edge on the serial clock pin only
    function edge_fall;
        input prev;
        input now;
        begin
            edge_fall = prev & ~now;
        end
    endfunction

    function edge_rise;
        input prev;
        input now;
        begin
            edge_rise = ~prev & now;
        end
    endfunction

    wire cs_fall = edge_fall(pin_d[PIN_CS], pin_s[PIN_CS]);
    wire sc_fall = edge_fall(pin_d[PIN_SC], pin_s[PIN_SC]);
    wire sc_rise = edge_rise(pin_d[PIN_SC], pin_s[PIN_SC]);

    // ********************************************
    // Input multiplexer
    // ********************************************
    reg [RES_BITS-1:0] mux_out;

    always @* begin
        mux_out = sample_in;
        if (sel_half) begin
            mux_out = half_in;
        end
    end

    // ********************************************
    // Sequencer
    // ********************************************
    reg [1:0] state;
    reg [`ACSR_CNT_W-1:0] cnt;
    reg [`ACSR_BIT_CNT_W-1:0] bits_left;
    reg [RES_BITS-1:0] held;
    reg [RES_BITS-1:0] shreg;
    reg pend_half;

    always @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            cnt <= {`ACSR_CNT_W{1'b0}};
            bits_left <= {`ACSR_BIT_CNT_W{1'b0}};
            held <= {RES_BITS{1'b0}};
            shreg <= {RES_BITS{1'b0}};
            result <= {RES_BITS{1'b0}};
            pend_half <= 1'b0;
            sel_half <= 1'b0;
            busy <= 1'b0;
            dout <= 1'b0;
            dout_oe_n <= 1'b1;
        end else if (ce) begin
            case (state)
                ST_IDLE, ST_SHIFT: begin
                    if (cs_fall) begin
                        state <= ST_TRACK;
                        cnt <= {`ACSR_CNT_W{1'b0}};
                        busy <= 1'b1;
                        sel_half <= pend_half;
                        pend_half <= 1'b0;
                        dout <= 1'b0;
                        dout_oe_n <= 1'b0;
                    end else if (state == ST_SHIFT) begin
                        // advance on falling edge, MSB first
                        if (sc_fall && bits_left != {`ACSR_BIT_CNT_W{1'b0}}) begin
                            dout <= shreg[RES_BITS-1];
                            shreg <= {shreg[RES_BITS-2:0], 1'b0};
                        end
                        if (sc_rise) begin
                            if (bits_left == BIT_ONE) begin
                                dout_oe_n <= 1'b1;
                                state <= ST_IDLE;
                            end
                            bits_left <= bits_left - BIT_ONE;
                        end
                    end
                end
                ST_TRACK, ST_CONV: begin
                    if (cs_fall) begin
                        state <= ST_IDLE;
                        busy <= 1'b0;
                        pend_half <= 1'b1;
                        dout_oe_n <= 1'b1;
                    end else begin
                        cnt <= cnt + 16'h0001;
                        if (state == ST_TRACK && cnt == ACQ_CYC) begin
                            held <= mux_out;
                            state <= ST_CONV;
                        end
                        if (state == ST_CONV && cnt == CONV_CYC) begin
                            result <= held;
                            dout <= held[RES_BITS-1];
                            shreg <= {held[RES_BITS-2:0], 1'b0};
                            bits_left <= BITS_INIT;
                            busy <= 1'b0;
                            state <= ST_SHIFT;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule // acsr_core
`default_nettype wire

// [rtl/acsr_map.vh]
// Timing and width constants for the conversion and serial readout block
`ifndef ACSR_MAP_VH
`define ACSR_MAP_VH
`define ACSR_RES_BITS 8
`define ACSR_CONV_TIME_NS 7500
`define ACSR_CLK_PERIOD_NS 25
`define ACSR_ACQ_CYCLES 16'h0028
`define ACSR_CNT_W 16
`define ACSR_BIT_CNT_W 4
`define ACSR_SYNC_CYCLES 3
`define ACSR_PIN_RST 2'h3
`endif

// [verif/acsr_chk.sv]
// Port checker for the conversion and serial readout block
`timescale 1ns/1ps
`default_nettype none
module acsr_chk(input wire clk, srst, ce, convert_start_n, sclk, dout, dout_oe_n, busy,
    sel_half, input wire [7:0] sample_in, half_in, result);
default clocking @(posedge clk); endclocking
default disable iff (srst);
property p_low; busy |-> !dout_oe_n && !dout; endproperty
a_low: assert property (p_low) else $error("dout not low while busy");
property p_track; $rose(busy) |-> busy[*8]; endproperty
a_track: assert property (p_track) else $error("track phase cut short");
property p_bound; busy |-> ##[0:300] !busy; endproperty
a_bound: assert property (p_bound) else $error("conversion too long");
property p_msb; $fell(busy) && !dout_oe_n |-> dout == result[7]; endproperty
a_msb: assert property (p_msb) else $error("msb not on dout");
property p_sel; $fell(busy) && !dout_oe_n |-> result == (sel_half ? half_in : sample_in);
endproperty
a_sel: assert property (p_sel) else $error("wrong result source");
property p_hold; !$fell(busy) |-> $stable(result); endproperty
a_hold: assert property (p_hold) else $error("result changed");
property p_idle; $fell(srst) |-> dout_oe_n; endproperty
a_idle: assert property (p_idle) else $error("dout driven after reset");
property p_start; $fell(convert_start_n) && !busy |-> ##[1:6] busy; endproperty
a_start: assert property (p_start) else $error("start not taken");
property p_abort; $fell(convert_start_n) && busy |-> ##[1:6] !busy && dout_oe_n; endproperty
a_abort: assert property (p_abort) else $error("abort not taken");
c_done: cover property ($fell(busy) && !dout_oe_n);
c_abort: cover property ($fell(busy) && dout_oe_n);
c_rel: cover property (!busy && $rose(dout_oe_n));
endmodule // acsr_chk
bind acsr_core acsr_chk u_chk(.clk, .srst, .ce, .convert_start_n, .sclk, .dout, .dout_oe_n,
    .busy, .sel_half, .sample_in, .half_in, .result);
`default_nettype wire

// [verif/acsr_master.sv]
// Serial master model: start pulses and result readout
`timescale 1ns/1ps
`default_nettype none
module acsr_master(input wire clk, input wire dpin, output logic convert_start_n,
    output logic sclk);
initial begin
    convert_start_n = 1'b1;
    sclk = 1'b1;
end
// one pulse, repeated for half supply
task automatic start();
    @(posedge clk) convert_start_n <= 1'b0;
    repeat (4) @(posedge clk);
    convert_start_n <= 1'b1;
    repeat (4) @(posedge clk);
endtask
task automatic read(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
        @(negedge clk) v[i] = dpin;
        @(posedge clk) sclk <= 1'b0;
        repeat (4) @(posedge clk);
        sclk <= 1'b1;
        repeat (3) @(posedge clk);
    end
endtask
endmodule // acsr_master
`default_nettype wire

// [verif/tb_adc_convert_serial_readout.sv]
// Testbench for the conversion and serial readout block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_convert_serial_readout;
logic clk, srst, ce;
logic [7:0] sample_in, half_in, v;
wire cs_n, sclk, dout, dout_oe_n, busy, sel_half, dpin;
wire [7:0] result;
int miscompares = 0, samples_checked = 0, cyc = 0;
assign dpin = dout_oe_n ? ~dout : dout;
acsr_core DUT(.clk, .srst, .ce, .convert_start_n(cs_n), .sclk, .sample_in, .half_in, .dout,
    .dout_oe_n, .busy, .sel_half, .result);
acsr_master u_m(.clk, .dpin, .convert_start_n(cs_n), .sclk);
task check(logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
        miscompares++;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task conclude();
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask
task t_chan(logic [7:0] s);
    sample_in <= s;
    u_m.start();
    @(negedge clk) check({5'h00, busy, dout_oe_n, dpin}, 8'h04);
    u_m.read(v);
    repeat (240) @(posedge clk);
    u_m.read(v);
    check(v, s);
    repeat (8) @(posedge clk);
    @(negedge clk) check({7'h00, dout_oe_n}, 8'h01);
    check(result, s);
    $display("channel test done");
endtask
task t_half();
    u_m.start();
    repeat (40) @(posedge clk);
    u_m.start();
    @(negedge clk) check({6'h00, busy, dout_oe_n}, 8'h01);
    u_m.start();
    repeat (300) @(posedge clk);
    check({7'h00, sel_half}, 8'h01);
    u_m.read(v);
    check(v, half_in);
    $display("half supply test done");
endtask
initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
end
always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
        miscompares++;
        conclude();
    end
end
initial begin
    srst = 1'b1;
    ce = 1'b1;
    sample_in = 8'h00;
    half_in = 8'h81;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk) check({7'h00, dout_oe_n}, 8'h01);
    t_chan(8'hA5);
    t_chan(8'h5A);
    t_half();
    t_chan(8'hC3);
    conclude();
end
endmodule // tb_adc_convert_serial_readout
`default_nettype wire
